// ==== crtc_pkg.sv ====
// constants shared by the refresh/cursor/pen block and its buffer
// assumes a single 25 MHz character clock and the indexed host port
package crtc_pkg;
  // internal register numbers behind the index register
  localparam logic [4:0] REG_SKEW  = 5'h08;
  localparam logic [4:0] REG_SCANS = 5'h09;
  localparam logic [4:0] REG_CSTRT = 5'h0a;
  localparam logic [4:0] REG_CEND  = 5'h0b;
  localparam logic [4:0] REG_SAH   = 5'h0c;
  localparam logic [4:0] REG_SAL   = 5'h0d;
  localparam logic [4:0] REG_CLH   = 5'h0e;
  localparam logic [4:0] REG_CLL   = 5'h0f;
  localparam logic [4:0] REG_PENH  = 5'h10;
  localparam logic [4:0] REG_PENL  = 5'h11;

  // field positions
  localparam int DISP_SKEW_LSB  = 4;
  localparam int CUR_SKEW_LSB   = 6;
  localparam int BLINK_EN_BIT   = 6;
  localparam int BLINK_RATE_BIT = 5;
  localparam int BLINK_FAST_BIT = 3;
  localparam int BLINK_SLOW_BIT = 4;
  localparam logic [1:0] SKEW_OFF = 2'h3;

  // reset values
  localparam logic [7:0]  SKEW_RST  = 8'h00;
  localparam logic [4:0]  SCANS_RST = 5'h07;
  localparam logic [6:0]  CSTRT_RST = 7'h00;
  localparam logic [4:0]  CEND_RST  = 5'h07;
  localparam logic [13:0] ADDR_RST  = 14'h0000;

  // frame geometry used by the refresh counters
  localparam logic [7:0] H_TOTAL = 8'h3f;
  localparam logic [7:0] H_DISP  = 8'h28;
  localparam logic [6:0] V_TOTAL = 7'h26;
  localparam logic [6:0] V_DISP  = 7'h20;

  // output buffer shape
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;
endpackage

// ==== skew_delay.sv ====
// programmable 0/1/2 character delay of one enable, code 3 forces off
// assumes advance marks each character time on the same clock
`timescale 1ns/1ps
module skew_delay
  import crtc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       advance,
  input  wire logic [1:0] skew,
  // enable in and out
  input  wire logic       din,
  output logic            dout
);
  logic [1:0] stage_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_q <= 2'h0;
    end else if (advance) begin
      stage_q <= {stage_q[0], din};
    end
  end

  always_comb begin
    case (skew)
      2'h0:    dout = din;
      2'h1:    dout = stage_q[0];
      2'h2:    dout = stage_q[1];
      default: dout = 1'b0;
    endcase
  end
endmodule

// ==== raster_fifo.sv ====
// small first-in first-out buffer with valid/ready on both sides
// assumes one clock; DEPTH is a power of two
`timescale 1ns/1ps
module raster_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             push;
  logic             pop;

  assign inReady  = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
  assign outValid = wrPtr_q != rdPtr_q;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem_q[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + (AW+1)'(1);
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + (AW+1)'(1);
      end
    end
  end
endmodule

// ==== crtc_refresh.sv ====
// refresh address, cursor, light pen and start address part of a crt controller
// assumes host on the indexed byte port, video memory fetch downstream of the buffer
`timescale 1ns/1ps
// Notes on behaviour
// R1: display skew bits 4-5 delay; code 3 blanks
// R2: cursor skew bits 6-7 delay; code 3 disables
// R3: scan lines per row is value plus one
// R4: cursor start bit 6 selects blinking, bit 7 unused
// R5: bit 5 picks blink at 1/16 or 1/32 field
// R6: low five bits give cursor start line
// R7: five-bit cursor end line
// R8: cursor location 14 bits, read and write
// R9: cursor shown where address matches, within lines
// R10: pen strobe high loads pen register with address
// R11: pen position kept per character only
// R12: start address 14 bits, write only, split 8/6
// R13: first frame address equals start address
// R14: start address registers read back as zero
// R15: external logic wraps addresses above 0x7fff
// R16: host scrolls rows by adding characters per line
// R17: host scrolls sideways by adding or subtracting one
// R18: host keeps start address inside screen memory
// R19: host divides byte address by eight first
// R20: host selects register via index then data
// R21: address advances per character, rows continue on
// R22: strobe synchronised, one capture per rising edge
module crtc_refresh
  import crtc_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // host port
  input  wire logic         busSelect,
  input  wire logic         busDataSel,
  input  wire logic         busWrite,
  input  wire logic [7:0]   busWriteData,
  output logic [7:0]        busReadData,
  // light pen pin
  input  wire logic         penStrobe,
  // raster stream to video memory and monitor
  output logic              rasterValid,
  input  wire logic         rasterReady,
  output logic [13:0]       memAddr,
  output logic              dispEnable,
  output logic              cursorOut
);
  logic [4:0]  regIndex_q;
  logic [7:0]  skewCtl_q;
  logic [4:0]  scanLines_q;
  logic [6:0]  cursorStart_q;
  logic [4:0]  cursorEnd_q;
  logic [13:0] startAddr_q;
  logic [13:0] cursorLoc_q;
  logic [13:0] penLoc_q;
  logic [7:0]  readData_d;
  logic [7:0]  busReadData_q;
  logic [7:0]  charCnt_q;
  logic [4:0]  scanCnt_q;
  logic [6:0]  rowCnt_q;
  logic [13:0] ma_q;
  logic [13:0] rowStart_q;
  logic [4:0]  blinkCnt_q;
  logic        penSync1_q;
  logic        penSync2_q;
  logic        penPrev_q;
  logic        penEdge;
  logic        advance;
  logic        lineEnd;
  logic        rowEnd;
  logic        frameEnd;
  logic        displayRaw;
  logic        blinkPhase;
  logic        cursorRaw;
  logic        dispDelayed;
  logic        curDelayed;
  logic        fifoInReady;
  logic        hostWrite;
  logic [FIFO_WIDTH-1:0] fifoOut;

  assign hostWrite = busSelect && busWrite;

  // index register, then the data location reaches the selected register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regIndex_q <= 5'h00;
    end else if (hostWrite && !busDataSel) begin
      regIndex_q <= busWriteData[4:0]; // [R20]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      skewCtl_q     <= SKEW_RST;
      scanLines_q   <= SCANS_RST;
      cursorStart_q <= CSTRT_RST;
      cursorEnd_q   <= CEND_RST;
      startAddr_q   <= ADDR_RST;
      cursorLoc_q   <= ADDR_RST;
    end else if (hostWrite && busDataSel) begin
      case (regIndex_q)
        REG_SKEW:  skewCtl_q <= busWriteData; // [R1] [R2]
        REG_SCANS: scanLines_q <= busWriteData[4:0]; // [R3]
        REG_CSTRT: cursorStart_q <= busWriteData[6:0]; // [R4] [R6]
        REG_CEND:  cursorEnd_q <= busWriteData[4:0]; // [R7]
        REG_SAH:   startAddr_q[13:8] <= busWriteData[5:0]; // [R12]
        REG_SAL:   startAddr_q[7:0] <= busWriteData; // [R12]
        REG_CLH:   cursorLoc_q[13:8] <= busWriteData[5:0]; // [R8]
        REG_CLL:   cursorLoc_q[7:0] <= busWriteData; // [R8]
        default:   ;
      endcase
    end
  end

  // write-only registers and the index read as zero
  always_comb begin
    readData_d = 8'h00; // [R14]
    if (busDataSel) begin
      case (regIndex_q)
        REG_CLH:  readData_d = {2'h0, cursorLoc_q[13:8]}; // [R8]
        REG_CLL:  readData_d = cursorLoc_q[7:0];
        REG_PENH: readData_d = {2'h0, penLoc_q[13:8]};
        REG_PENL: readData_d = penLoc_q[7:0];
        default:  readData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busReadData_q <= 8'h00;
    end else begin
      busReadData_q <= readData_d;
    end
  end

  assign busReadData = busReadData_q;

  // a full buffer stalls the whole raster so no character is dropped
  assign advance    = fifoInReady;
  assign lineEnd    = charCnt_q == H_TOTAL;
  assign rowEnd     = lineEnd && (scanCnt_q >= scanLines_q);
  assign frameEnd   = rowEnd && (rowCnt_q == V_TOTAL);
  assign displayRaw = (charCnt_q < H_DISP) && (rowCnt_q < V_DISP);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      charCnt_q <= 8'h00;
    end else if (advance) begin
      charCnt_q <= lineEnd ? 8'h00 : charCnt_q + 8'h01;
    end
  end

  // >= so that lowering the setting mid-row still ends the row
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scanCnt_q <= 5'h00;
      rowCnt_q  <= 7'h00;
    end else if (advance && lineEnd) begin
      if (rowEnd) begin
        scanCnt_q <= 5'h00; // [R3]
        rowCnt_q  <= frameEnd ? 7'h00 : rowCnt_q + 7'h01;
      end else begin
        scanCnt_q <= scanCnt_q + 5'h01;
      end
    end
  end

  // refresh address: one per displayed character, rows continue on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ma_q       <= ADDR_RST;
      rowStart_q <= ADDR_RST;
    end else if (advance) begin
      if (frameEnd) begin
        ma_q       <= startAddr_q; // [R13]
        rowStart_q <= startAddr_q;
      end else if (rowEnd) begin
        ma_q       <= 14'(rowStart_q + {6'h00, H_DISP}); // [R21]
        rowStart_q <= 14'(rowStart_q + {6'h00, H_DISP});
      end else if (lineEnd) begin
        ma_q <= rowStart_q;
      end else if (displayRaw) begin
        ma_q <= ma_q + 14'h0001; // [R21]
      end
    end
  end

  // field counter drives the cursor blink
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blinkCnt_q <= 5'h00;
    end else if (advance && frameEnd) begin
      blinkCnt_q <= blinkCnt_q + 5'h01;
    end
  end

  assign blinkPhase = cursorStart_q[BLINK_RATE_BIT] ? !blinkCnt_q[BLINK_SLOW_BIT]
                                                    : !blinkCnt_q[BLINK_FAST_BIT]; // [R5]
  assign cursorRaw  = displayRaw && (ma_q == cursorLoc_q)
                      && (scanCnt_q >= cursorStart_q[4:0]) && (scanCnt_q <= cursorEnd_q)
                      && (!cursorStart_q[BLINK_EN_BIT] || blinkPhase); // [R9] [R4] [R6]

  skew_delay dispSkew (
    .clk     (clk),
    .rst_n   (rst_n),
    .advance (advance),
    .skew    (skewCtl_q[DISP_SKEW_LSB+:2]),
    .din     (displayRaw),
    .dout    (dispDelayed)
  ); // [R1]

  skew_delay curSkew (
    .clk     (clk),
    .rst_n   (rst_n),
    .advance (advance),
    .skew    (skewCtl_q[CUR_SKEW_LSB+:2]),
    .din     (cursorRaw),
    .dout    (curDelayed)
  ); // [R2]

  raster_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) outBuf (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (1'b1),
    .inReady  (fifoInReady),
    .inData   ({ma_q, dispDelayed, curDelayed}),
    .outValid (rasterValid),
    .outReady (rasterReady),
    .outData  (fifoOut)
  );

  assign memAddr    = fifoOut[15:2];
  assign dispEnable = fifoOut[1];
  assign cursorOut  = fifoOut[0];

  // pen strobe is asynchronous; only the second flop feeds the edge detect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      penSync1_q <= 1'b0;
      penSync2_q <= 1'b0;
      penPrev_q  <= 1'b0;
    end else begin
      penSync1_q <= penStrobe; // [R22]
      penSync2_q <= penSync1_q;
      penPrev_q  <= penSync2_q;
    end
  end

  assign penEdge = penSync2_q && !penPrev_q; // [R22]

  // capture is of the character address only, two cycles of sync latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      penLoc_q <= ADDR_RST;
    end else if (penEdge) begin
      penLoc_q <= ma_q; // [R10] [R11]
    end
  end

  scan_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    (advance && rowEnd) |=> (scanCnt_q == 5'h00))
    else $error("scan line count did not restart after last line");

  frame_start_a: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    (advance && frameEnd) |=> (ma_q == $past(startAddr_q)))
    else $error("frame did not start at the start address");

  char_step_a: assert property (@(posedge clk) disable iff (!rst_n) // [R21]
    (advance && !lineEnd && displayRaw) |=> (ma_q == 14'($past(ma_q) + 14'h0001)))
    else $error("refresh address did not step by one");

  pen_load_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    $rose(penSync2_q) |=> (penLoc_q == $past(ma_q)))
    else $error("pen register missed the strobe address");

  pen_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [R22]
    (penSync2_q && penPrev_q) [*2] |=> $stable(penLoc_q))
    else $error("pen register reloaded while strobe held high");

  disp_off_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    (skewCtl_q[DISP_SKEW_LSB+:2] == SKEW_OFF) |-> !dispDelayed)
    else $error("display enable active with blanking code");

  cur_off_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    (skewCtl_q[CUR_SKEW_LSB+:2] == SKEW_OFF) |-> !curDelayed)
    else $error("cursor active with disable code");

  cur_lines_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    cursorRaw |-> (scanCnt_q >= cursorStart_q[4:0]) && (scanCnt_q <= cursorEnd_q) && (ma_q == cursorLoc_q))
    else $error("cursor outside its lines or position");

  start_hidden_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
    (busDataSel && (regIndex_q == REG_SAH || regIndex_q == REG_SAL)) |=> (busReadData == 8'h00))
    else $error("start address read back its contents");

  cur_write_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    (hostWrite && busDataSel && regIndex_q == REG_CLL) ##1 (busDataSel && regIndex_q == REG_CLL && !hostWrite)
      |=> (busReadData == $past(cursorLoc_q[7:0], 1)) && (cursorLoc_q[7:0] == $past(busWriteData, 2)))
    else $error("cursor location low byte not stored or read");
endmodule

// ==== raster_monitor.sv ====
// raster monitor standing in for video memory and the display
// assumes one entry per handshake; stall and slow pace the ready line
`timescale 1ns/1ps
module raster_monitor (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // pacing from the bench
  input  wire logic        stall,
  input  wire logic        slow,
  // raster stream
  input  wire logic        rasterValid,
  output logic             rasterReady,
  input  wire logic [13:0] memAddr,
  input  wire logic        dispEnable,
  input  wire logic        cursorOut
);
  logic        tick_q;
  logic [13:0] prevAddr, curAddr;
  logic [13:0] lineAddr [16];
  int          gap, lineIdx, frames, curFrames, curCnt, dispCnt, seqErr;
  // screen length in bytes that the wrap circuit folds back; plain default
  localparam logic [16:0] WRAP_LEN = 17'h05000;
  logic [16:0] fetchAddr;
  logic [16:0] topFetch;
  // slow mode takes an entry every other cycle, so the buffer fills and drains
  assign rasterReady = !stall && !(slow && tick_q);
  // byte fetch above the top of video ram is pulled back inside it
  assign fetchAddr = ({memAddr, 3'h0} > 17'h07fff) ? {memAddr, 3'h0} - WRAP_LEN : {memAddr, 3'h0};
  always_ff @(posedge clk) begin
    tick_q <= rst_n && !tick_q;
  end
  // a long blank run marks a frame top, a short one a new line
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap <= 100;
      frames <= 0;
      curFrames <= 0;
      dispCnt <= 0;
      seqErr <= 0;
    end else if (rasterValid && rasterReady && !dispEnable) begin
      gap <= gap + 1;
    end else if (rasterValid && rasterReady) begin
      gap <= 0;
      dispCnt <= dispCnt + 1;
      prevAddr <= memAddr;
      if (gap > 64) begin
        frames <= frames + 1;
        topFetch <= fetchAddr;
        lineIdx <= 1;
        lineAddr[0] <= memAddr;
        if (curCnt > 0) curFrames <= curFrames + 1;
      end else if (gap > 0) begin
        if (lineIdx < 16) lineAddr[lineIdx] <= memAddr;
        lineIdx <= lineIdx + 1;
      end else if (memAddr !== prevAddr + 14'h1) begin
        seqErr <= seqErr + 1;
      end
      if (cursorOut) curAddr <= memAddr;
      curCnt <= (gap > 64) ? 0 : curCnt + int'(cursorOut);
    end
  end
endmodule

// ==== tb.sv ====
// bench for the refresh, cursor and pen block and its raster buffer
// assumes the indexed host port and the raster monitor on the stream
`timescale 1ns/1ps
module tb;
  import crtc_pkg::*;
  typedef struct packed {
    logic [4:0] idx;
    logic [7:0] val;
    logic [7:0] exp;
  } row_t;
  logic        clk, rst_n, busSelect, busDataSel, busWrite, penStrobe, stall, slow;
  logic        rasterValid, rasterReady, dispEnable, cursorOut;
  logic [7:0]  busWriteData, busReadData, r;
  logic [13:0] memAddr, sa, pen;
  int          nFail, compares, t, n, s;
  row_t        rows [8] = '{
    '{REG_CLH, 8'hff, 8'h3f},
    '{REG_CLL, 8'ha5, 8'ha5},
    '{REG_SAH, 8'h2b, 8'h00},
    '{REG_SAL, 8'hcd, 8'h00},
    '{REG_SKEW, 8'h00, 8'h00},
    '{REG_CEND, 8'h07, 8'h00},
    '{REG_PENL, 8'hff, 8'h00},
    '{5'h12, 8'h77, 8'h00}
  };

  crtc_refresh dut_u (.clk(clk), .rst_n(rst_n), .busSelect(busSelect), .busDataSel(busDataSel),
    .busWrite(busWrite), .busWriteData(busWriteData), .busReadData(busReadData), .penStrobe(penStrobe),
    .rasterValid(rasterValid), .rasterReady(rasterReady), .memAddr(memAddr), .dispEnable(dispEnable),
    .cursorOut(cursorOut));
  raster_monitor mon_u (.clk(clk), .rst_n(rst_n), .stall(stall), .slow(slow), .rasterValid(rasterValid),
    .rasterReady(rasterReady), .memAddr(memAddr), .dispEnable(dispEnable), .cursorOut(cursorOut));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // index first, then the data location
  task automatic wr(input logic [4:0] idx, input logic [7:0] val);
    @(negedge clk);
    busSelect = 1'b1;
    busWrite = 1'b1;
    busDataSel = 1'b0;
    busWriteData = {3'h0, idx};
    @(negedge clk);
    busDataSel = 1'b1;
    busWriteData = val;
    @(negedge clk);
    busSelect = 1'b0;
    busWrite = 1'b0;
  endtask

  // index write only, then the data location with no write, so nothing is disturbed
  task automatic rd(input logic [4:0] idx, output logic [7:0] val);
    @(negedge clk);
    busSelect = 1'b1;
    busWrite = 1'b1;
    busDataSel = 1'b0;
    busWriteData = {3'h0, idx};
    @(negedge clk);
    busSelect = 1'b0;
    busWrite = 1'b0;
    busDataSel = 1'b1;
    @(negedge clk);
    val = busReadData;
  endtask

  task automatic rdPen();
    logic [7:0] h;
    logic [7:0] l;
    rd(REG_PENH, h);
    rd(REG_PENL, l);
    pen = {h[5:0], l};
  endtask

  task automatic wr14(input logic [4:0] hiIdx, input logic [13:0] v);
    wr(hiIdx, {2'h0, v[13:8]});
    wr(hiIdx + 5'h1, v[7:0]);
  endtask

  task automatic waitFrames(input int k);
    int f;
    for (int i = 0; i < k; i++) begin
      f = mon_u.frames;
      for (int c = 0; c < 30000 && mon_u.frames == f; c++) @(negedge clk);
    end
    repeat (800) @(negedge clk);
  endtask

  task automatic closeOut();
    if (nFail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // about 100k cycles of traffic are expected
  initial begin
    repeat (130000) @(posedge clk);
    nFail++;
    closeOut();
  end

  initial begin
    {rst_n, busSelect, busDataSel, busWrite, penStrobe, stall, slow} = 7'h0;
    busWriteData = 8'h00;
    nFail = 0;
    compares = 0;
    repeat (12) @(negedge clk);
    check("validInReset", 16'h0, {15'h0, rasterValid});
    rst_n = 1'b1;
    rd(REG_CLL, r);
    check("curLocReset", 16'h0, {8'h0, r});
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].val);
      rd(rows[i].idx, r);
      check("regRead", {8'h0, rows[i].exp}, {8'h0, r});
    end
    // first frame: four lines per row, cursor on lines 2..3 of row 1
    sa = 14'(16'h5800 >> 3);
    wr14(REG_SAH, sa);
    wr(REG_SCANS, 8'h03);
    wr(REG_CSTRT, 8'h02);
    wr(REG_CEND, 8'h03);
    wr14(REG_CLH, sa + 14'd41);
    waitFrames(2);
    check("frameTop", {2'h0, sa}, {2'h0, mon_u.lineAddr[0]});
    check("rowRepeat", {2'h0, sa}, {2'h0, mon_u.lineAddr[3]});
    check("nextRow", {2'h0, sa + 14'd40}, {2'h0, mon_u.lineAddr[4]});
    check("curAddr", {2'h0, sa + 14'd41}, {2'h0, mon_u.curAddr});
    check("curLines", 16'd2, 16'(mon_u.curCnt));
    check("topFetch", 16'h5800, 16'(mon_u.topFetch));
    // a two character skew repeats the held blanking address, so sequence is judged at skew 0
    check("seqBreaks", 16'd0, 16'(mon_u.seqErr));
    // stall the stream; the full buffer freezes the counters at head plus four
    for (t = 0; t < 30000 && !(rasterValid === 1'b1 && dispEnable === 1'b1 && memAddr === sa + 14'd5); t++)
      @(negedge clk);
    stall = 1'b1;
    repeat (6) @(negedge clk);
    penStrobe = 1'b1;
    @(negedge clk);
    penStrobe = 1'b0;
    rdPen();
    check("penCapture", {2'h0, sa + 14'd9}, {2'h0, pen});
    penStrobe = 1'b1;
    repeat (6) @(negedge clk);
    stall = 1'b0;
    repeat (20) @(negedge clk);
    rdPen();
    check("penHeld", {2'h0, sa + 14'd9}, {2'h0, pen});
    penStrobe = 1'b0;
    // one line per row, cursor on line 0; skew codes 0..2 on both enables
    wr(REG_SCANS, 8'h00);
    wr(REG_CEND, 8'h00);
    wr(REG_CSTRT, 8'h00);
    for (int d = 0; d < 3; d++) begin
      sa = sa + 14'd1;
      wr14(REG_SAH, sa);
      wr14(REG_CLH, sa + 14'd41);
      wr(REG_SKEW, {2'(d), 2'(d), 4'h0});
      slow = (d == 1);
      waitFrames(2);
      check("skewTop", {2'h0, sa + 14'(d)}, {2'h0, mon_u.lineAddr[0]});
      check("skewRow", {2'h0, sa + 14'(40 + d)}, {2'h0, mon_u.lineAddr[1]});
      check("skewCur", {2'h0, sa + 14'(41 + d)}, {2'h0, mon_u.curAddr});
    end
    slow = 1'b0;
    wr(REG_SKEW, 8'hf0);
    repeat (20) @(negedge clk);
    n = mon_u.dispCnt;
    repeat (3000) @(negedge clk);
    check("blanked", 16'(n), 16'(mon_u.dispCnt));
    // fast blink: any sixteen frames show the cursor in exactly eight
    wr(REG_SKEW, 8'h00);
    sa = sa + 14'd40;
    wr14(REG_SAH, sa);
    wr14(REG_CLH, sa + 14'd41);
    wr(REG_CSTRT, 8'h40);
    // the end of the blanked run looks like a frame top, so skip past a real one
    waitFrames(2);
    n = mon_u.curFrames;
    s = mon_u.seqErr;
    waitFrames(16);
    check("blinkFrames", 16'd8, 16'(mon_u.curFrames - n));
    check("seqBreaks", 16'(s), 16'(mon_u.seqErr));
    // reset in mid-run brings back the reset values
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("validInReset", 16'h0, {15'h0, rasterValid});
    rst_n = 1'b1;
    rd(REG_CLL, r);
    check("curLocReset", 16'h0, {8'h0, r});
    rd(REG_PENL, r);
    check("penReset", 16'h0, {8'h0, r});
    closeOut();
  end
endmodule
